// ==== hw/paged_flash_controller.sv ====
module paged_flash_controller
  import flash_ctrl_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter int PROG_CYCLES  = PROG_CYC
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  output logic            busy,
  output logic            core_stall,
  output logic            irq_hold,
  output logic            verify_ok
);
  logic [7:0] flash_command;
  logic [7:0] flash_access_key;
  logic [7:0] protection_change_key;
  logic [7:0] flash_byte_buffer;
  logic [7:0] write_erase_protect_low;
  logic [7:0] write_erase_protect_high;
  logic [7:0] read_protect_groups;
  logic [7:0] flash_addr_low;
  logic [7:0] flash_addr_high;
  state_e     state;
  state_e     next_state;
  logic [7:0] cnt;
  logic [7:0] last_wdata;
  logic [1:0] prot_idx;
  logic       erase_first;

  logic [ADDR_BITS-1:0] arr_addr;
  logic [7:0]           arr_rdata;
  logic                 arr_prog;
  logic                 arr_erase_page;
  logic                 arr_erase_all;
  logic [7:0]           arr_wdata;
  logic [47:0]          arr_prot;

  wire [ADDR_BITS-1:0] user_addr = {flash_addr_high[5:0], flash_addr_low}; // [R11]
  wire [4:0]           page      = user_addr[ADDR_BITS-1:PAGE_BITS]; // [R3]
  wire                 cmd_wr    = sfr_wr && sfr_addr == ADDR_COMMAND && state == ST_IDLE;
  wire                 key_ok    = flash_access_key == ACCESS_KEY_VALUE; // [R14] [R17]

  // Stored protection copied from page 31 into registers
  logic [7:0] stored_key;
  logic [7:0] stored_rd;
  logic [31:0] stored_wep;
  logic        ctl_snap;

  function automatic logic page_bit(input logic [31:0] map, input logic [4:0] p);
    return map[p];
  endfunction : page_bit

  // Active protection uses the stored page 31 bytes, zero meaning protected
  wire page_locked = !page_bit(stored_wep, page); // [R6] [R19]
  wire read_locked = !stored_rd[page[4:2]]; // [R7]
  wire prot_key_ok = stored_key == ERASED || stored_key == protection_change_key; // [R8]

  wire is_erase_cmd = sfr_wdata == CMD_ERASE_PAGE || sfr_wdata == CMD_ERASE_WRITE;
  wire is_prog_cmd  = sfr_wdata == CMD_WRITE || sfr_wdata == CMD_ERASE_WRITE;
  wire modifies     = is_erase_cmd || is_prog_cmd;

  always_comb begin
    next_state = ST_DONE; // [R20]
    case (sfr_wdata) // [R16]
      CMD_WRITE:       next_state = page_locked ? ST_DONE : ST_PROG;
      CMD_ERASE_PAGE,
      CMD_ERASE_WRITE: next_state = page_locked ? ST_DONE : ST_ERASE; // [R6]
      CMD_ERASE_ALL:   next_state = ST_ERASE; // [R4]
      CMD_READ:        next_state = ST_READ;
      CMD_VERIFY:      next_state = ST_VERIFY; // [R5]
      CMD_PROTECT:     next_state = prot_key_ok ? ST_PROT : ST_DONE; // [R8]
      default:         next_state = ST_DONE;
    endcase
  end

  assign arr_addr = (state == ST_PROT) ? LOC_PROT_LO + 14'(prot_idx) : user_addr;
  assign arr_erase_page = state == ST_ERASE && cnt == 8'd0 && !erase_first;
  assign arr_erase_all  = state == ST_ERASE && cnt == 8'd0 && erase_first;
  assign arr_prog = (state == ST_PROG && cnt == 8'd0) || state == ST_PROT; // [R1]
  assign arr_wdata = state == ST_PROT ?
                     (prot_idx == 2'd0 ? protection_change_key :
                      prot_idx == 2'd1 ? read_protect_groups :
                      prot_idx == 2'd2 ? write_erase_protect_low :
                      write_erase_protect_high) : flash_byte_buffer;

  flash_array #(.AW(ADDR_BITS)) u_array (
    .clk       (clk),
    .rstn      (rstn),
    .addr      (arr_addr),
    .prog      (arr_prog),
    .wdata     (arr_wdata),
    .erase_page(arr_erase_page),
    .erase_all (arr_erase_all),
    .rdata     (arr_rdata),
    .prot_bytes(arr_prot)
  );

  // Protection cache refreshed from the array once after reset and in ST_DONE after each operation
  always_ff @(posedge clk) begin
    if (!rstn) begin
      stored_key <= RST_ONES;
      stored_rd  <= RST_ONES;
      stored_wep <= 32'hffffffff;
      ctl_snap   <= 1'b0;
    end else if (state == ST_DONE || !ctl_snap) begin
      ctl_snap   <= 1'b1;
      stored_key <= arr_prot[7:0]; // [R9]
      stored_rd  <= arr_prot[15:8];
      stored_wep <= arr_prot[47:16];
    end
  end

  assign busy       = state != ST_IDLE; // [R21]
  assign core_stall = busy || cmd_wr; // [R18]
  assign irq_hold   = busy; // [R18]

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state       <= ST_IDLE;
      cnt         <= 8'd0;
      prot_idx    <= 2'd0;
      erase_first <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: if (cmd_wr) begin
          state       <= key_ok ? next_state : ST_IDLE; // [R14] [R13]
          erase_first <= sfr_wdata == CMD_ERASE_ALL;
          cnt         <= next_state == ST_PROG ? 8'(PROG_CYCLES - 1) : 8'(ERASE_CYCLES - 1);
          prot_idx    <= 2'd0;
        end
        ST_ERASE: if (cnt != 8'd0) cnt <= cnt - 8'd1;
          else if (flash_command == CMD_ERASE_WRITE) begin
            state <= ST_PROG; // erase then program
            cnt   <= 8'(PROG_CYCLES - 1);
          end else state <= ST_DONE;
        ST_PROG: if (cnt != 8'd0) cnt <= cnt - 8'd1; else state <= ST_DONE;
        ST_PROT: if (prot_idx == 2'd3) state <= ST_DONE; else prot_idx <= prot_idx + 2'd1;
        ST_READ, ST_VERIFY: state <= ST_DONE;
        ST_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Register file
  always_ff @(posedge clk) begin
    if (!rstn) begin
      flash_command            <= RST_ZERO; // [R15]
      flash_access_key         <= RST_ONES;
      protection_change_key    <= RST_ONES;
      flash_byte_buffer        <= RST_ZERO;
      write_erase_protect_low  <= RST_ONES;
      write_erase_protect_high <= RST_ONES;
      read_protect_groups      <= RST_ONES;
      flash_addr_low           <= RST_ZERO;
      flash_addr_high          <= RST_ZERO;
      last_wdata               <= RST_ONES;
      verify_ok                <= 1'b0;
    end else begin
      if (state == ST_DONE) flash_access_key <= RST_ONES; // [R17]
      else if (sfr_wr && sfr_addr == ADDR_ACC_KEY && !busy) flash_access_key <= sfr_wdata;
      if (cmd_wr) flash_command <= sfr_wdata;
      if (state == ST_PROG && cnt == 8'd0) last_wdata <= flash_byte_buffer;
      if (state == ST_VERIFY) verify_ok <= arr_rdata == last_wdata; // [R5]
      if (state == ST_READ) flash_byte_buffer <= read_locked ? ERASED : arr_rdata; // [R12]
      else if (!busy && sfr_wr) begin
        case (sfr_addr)
          ADDR_PROT_KEY: protection_change_key    <= sfr_wdata;
          ADDR_BUFFER:   flash_byte_buffer        <= sfr_wdata;
          ADDR_WEP_LOW:  write_erase_protect_low  <= sfr_wdata;
          ADDR_WEP_HIGH: write_erase_protect_high <= sfr_wdata;
          ADDR_RD_PROT:  read_protect_groups      <= sfr_wdata;
          ADDR_ADDR_LOW: flash_addr_low           <= sfr_wdata; // [R12]
          ADDR_ADDR_HI:  flash_addr_high          <= sfr_wdata;
          default: ;
        endcase
      end
    end
  end

  always_comb begin
    case (sfr_addr)
      ADDR_COMMAND:  sfr_rdata = flash_command;
      ADDR_ACC_KEY:  sfr_rdata = flash_access_key;
      ADDR_PROT_KEY: sfr_rdata = protection_change_key;
      ADDR_BUFFER:   sfr_rdata = flash_byte_buffer;
      ADDR_WEP_LOW:  sfr_rdata = write_erase_protect_low;
      ADDR_WEP_HIGH: sfr_rdata = write_erase_protect_high;
      ADDR_RD_PROT:  sfr_rdata = read_protect_groups;
      ADDR_ADDR_LOW: sfr_rdata = flash_addr_low;
      ADDR_ADDR_HI:  sfr_rdata = flash_addr_high;
      default:       sfr_rdata = RST_ZERO;
    endcase
  end

  a_key_gate: assert property (@(posedge clk) disable iff (!rstn) // [R14]
    cmd_wr && !key_ok |=> state == ST_IDLE) else $error("command ran without key");
  a_key_reset: assert property (@(posedge clk) disable iff (!rstn) // [R17]
    state == ST_DONE |=> flash_access_key == RST_ONES) else $error("key not cleared");
  a_busy_stall: assert property (@(posedge clk) disable iff (!rstn) // [R21]
    busy |-> core_stall && irq_hold) else $error("busy without stall");
  a_lock_write: assert property (@(posedge clk) disable iff (!rstn) // [R6]
    cmd_wr && key_ok && modifies && page_locked |=> state == ST_DONE)
    else $error("protected page modified");
  a_bad_cmd: assert property (@(posedge clk) disable iff (!rstn) // [R20]
    cmd_wr && key_ok && sfr_wdata == 8'h07 |=> state == ST_DONE) else $error("bad command ran");
  a_prog_clear: assert property (@(posedge clk) disable iff (!rstn) // [R1]
    arr_prog && state == ST_PROG |=> (arr_rdata & ~$past(arr_wdata)) == 8'h00 ||
    $past(arr_addr) != arr_addr) else $error("program set a bit");
  a_read_done: assert property (@(posedge clk) disable iff (!rstn) // [R12]
    state == ST_READ |=> state == ST_DONE ##1 !busy) else $error("read did not finish");
  a_erase_len: assert property (@(posedge clk) disable iff (!rstn) // [R4]
    $rose(state == ST_ERASE) |-> (state == ST_ERASE)[*5]) else $error("erase too short");
  a_read_lock: assert property (@(posedge clk) disable iff (!rstn) // [R7]
    state == ST_READ && read_locked |=> flash_byte_buffer == ERASED)
    else $error("locked group read");
  a_prot_key: assert property (@(posedge clk) disable iff (!rstn) // [R8]
    cmd_wr && key_ok && sfr_wdata == CMD_PROTECT && !prot_key_ok |=> state == ST_DONE)
    else $error("protection change without key");
endmodule : paged_flash_controller

// ==== pkg/flash_ctrl_pkg.sv ====
// Functional notes
// [R1] - Erased bytes read 0xff; programming only clears bits; only erase sets them. Here reset also fills the whole array with 0xff.
// [R2] - No single-byte erase; erasure always covers the whole addressed page.
// [R3] - 32 pages of 512 bytes; page number is the address above bit 8.
// [R4] - Erase either one selected page or the whole array at once.
// [R5] - A verify command checks that the previous write landed correctly.
// [R6] - Four protection bytes in page 31 gate every write or erase by page; mass erase here ignores them.
// [R7] - One byte in page 31 sets read protection per group of four pages.
// [R8] - One byte in page 31 holds the key for changing protection settings.
// [R9] - Top six bytes of page 31 hold protection data; 506 bytes stay user.
// [R10] - Software must write/erase protect page 31 when any protection is used.
// [R11] - Pages 0 to 30 are general storage; page 31 suits fixed constants.
// [R12] - Data register holds write or read byte; two address registers select byte.
// [R13] - Writing a defined value to the command register starts that operation.
// [R14] - Commands are refused unless preceded by the matching access key.
// [R15] - Command, data, addresses reset to zero; keys and protections to all ones.
// [R16] - 1 write, 2 page erase, 3 mass erase, 4 read, 5 erase+write, 8 protect.
// [R17] - Access key compared with 0x3b; key returns to 0xff after each operation.
// [R18] - Core stalls on the command write; interrupts deferred; peripherals run.
// [R19] - Bit n of a protection register maps page n of its eight; zero protects.
// [R20] - Unknown command or protected write/erase completes leaving the array unchanged.
// [R21] - Busy from command acceptance to completion stalls core and holds interrupts.
package flash_ctrl_pkg;
  localparam logic [7:0] ADDR_COMMAND  = 8'hb9;
  localparam logic [7:0] ADDR_ACC_KEY  = 8'hba;
  localparam logic [7:0] ADDR_PROT_KEY = 8'hbb;
  localparam logic [7:0] ADDR_BUFFER   = 8'hbc;
  localparam logic [7:0] ADDR_WEP_LOW  = 8'hbd;
  localparam logic [7:0] ADDR_WEP_HIGH = 8'hbe;
  localparam logic [7:0] ADDR_RD_PROT  = 8'hbf;
  localparam logic [7:0] ADDR_ADDR_LOW = 8'hc6;
  localparam logic [7:0] ADDR_ADDR_HI  = 8'hc7;

  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ONES = 8'hff;
  localparam logic [7:0] ERASED   = 8'hff;
  localparam logic [7:0] ACCESS_KEY_VALUE = 8'h3b;

  localparam logic [7:0] CMD_WRITE       = 8'h01;
  localparam logic [7:0] CMD_ERASE_PAGE  = 8'h02;
  localparam logic [7:0] CMD_ERASE_ALL   = 8'h03;
  localparam logic [7:0] CMD_READ        = 8'h04;
  localparam logic [7:0] CMD_ERASE_WRITE = 8'h05;
  localparam logic [7:0] CMD_VERIFY      = 8'h06;
  localparam logic [7:0] CMD_PROTECT     = 8'h08;

  localparam int PAGE_BITS   = 9;
  localparam int NUM_PAGES   = 32;
  localparam int ADDR_BITS   = 14;
  localparam int GROUP_PAGES = 4;

  // Protection bytes at the top of page 31
  localparam logic [13:0] LOC_PROT_KEY = 14'h3ffa;
  localparam logic [13:0] LOC_RD_PROT  = 14'h3ffb;
  localparam logic [13:0] LOC_WEP0     = 14'h3ffc;
  localparam logic [13:0] LOC_WEP3     = 14'h3fff;
  localparam logic [13:0] LOC_PROT_LO  = 14'h3ffa;

  localparam int ERASE_NS  = 20;
  localparam int PROG_NS   = 12;
  localparam int CLK_NS    = 4;
  localparam int ERASE_CYC = (ERASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROG_CYC  = (PROG_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'b0000001,
    ST_ERASE  = 7'b0000010,
    ST_PROG   = 7'b0000100,
    ST_READ   = 7'b0001000,
    ST_VERIFY = 7'b0010000,
    ST_PROT   = 7'b0100000,
    ST_DONE   = 7'b1000000
  } state_e;
endpackage : flash_ctrl_pkg

// ==== hw/flash_array.sv ====
module flash_array
  import flash_ctrl_pkg::*;
#(
  parameter int AW = ADDR_BITS
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic [AW-1:0] addr,
  input  wire logic          prog,
  input  wire logic [7:0]    wdata,
  input  wire logic          erase_page,
  input  wire logic          erase_all,
  output logic      [7:0]    rdata,
  output logic      [47:0]   prot_bytes
);
  localparam int DEPTH = 1 << AW;
  logic [7:0] mem [DEPTH];

  assign rdata = mem[addr];
  // Page 31 protection bytes exposed for the controller's cache
  assign prot_bytes = {mem[LOC_WEP3], mem[LOC_WEP3 - 14'd1], mem[LOC_WEP0 + 14'd1],
                       mem[LOC_WEP0], mem[LOC_RD_PROT], mem[LOC_PROT_KEY]}; // [R9]

  // Erase sets bits; programming can only clear them
  always_ff @(posedge clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (!rstn || erase_all) begin // [R1] [R4]
        mem[i] <= ERASED;
      end else if (erase_page && (i >> PAGE_BITS) == int'(addr[AW-1:PAGE_BITS])) begin // [R2]
        mem[i] <= ERASED;
      end else if (prog && i == int'(addr)) begin
        mem[i] <= mem[i] & wdata; // [R1]
      end
    end
  end
endmodule : flash_array

// ==== test/sfr_core_model.sv ====
module sfr_core_model
  import flash_ctrl_pkg::*;
(
  input  wire logic       clk,
  output logic      [7:0] sfr_addr,
  output logic            sfr_wr,
  output logic      [7:0] sfr_wdata,
  input  wire logic [7:0] sfr_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sfr_addr  = 8'h00;
    sfr_wr    = 1'b0;
    sfr_wdata = 8'h00;
  end
  // One-cycle strobe, launched off the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge clk);
    sfr_wr    = 1'b0;
    // Released data must not keep showing the last byte
    sfr_wdata = ~d;
  endtask : wr
  // Read path is combinational, so one settled cycle is enough
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    @(negedge clk);
    d = sfr_rdata;
  endtask : rd
endmodule : sfr_core_model

// ==== test/tb_paged_flash_controller.sv ====
module tb_paged_flash_controller
  import flash_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk;
  logic       rstn;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       busy;
  logic       core_stall;
  logic       irq_hold;
  logic       verify_ok;
  int         num_errors;
  int         num_checks;
  int         cycles;
  logic [7:0] ra [10] = '{8'hb9, 8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'hbf, 8'hc6, 8'hc7, 8'h10};
  logic [7:0] rv [10] = '{8'h00, 8'hff, 8'hff, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};

  paged_flash_controller dut (
    .clk        (clk),
    .rstn       (rstn),
    .sfr_addr   (sfr_addr),
    .sfr_wr     (sfr_wr),
    .sfr_wdata  (sfr_wdata),
    .sfr_rdata  (sfr_rdata),
    .busy       (busy),
    .core_stall (core_stall),
    .irq_hold   (irq_hold),
    .verify_ok  (verify_ok)
  );
  sfr_core_model core (
    .clk       (clk),
    .sfr_addr  (sfr_addr),
    .sfr_wr    (sfr_wr),
    .sfr_wdata (sfr_wdata),
    .sfr_rdata (sfr_rdata)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic end_sim();
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Waits out the operation; the flag says whether it ever went busy
  task automatic run_cmd(input logic [7:0] c, input logic key, input logic exp_busy);
    logic seen;
    seen = 1'b0;
    if (key) core.wr(ADDR_ACC_KEY, ACCESS_KEY_VALUE);
    core.wr(ADDR_COMMAND, c);
    for (int n = 0; n < 40; n++) begin
      if (busy === 1'b1) begin
        seen = 1'b1;
        check("core_stall", {7'h00, core_stall}, 8'h01);
        check("irq_hold", {7'h00, irq_hold}, 8'h01);
      end else if (seen) begin
        break;
      end
      @(negedge clk);
    end
    check("busy_seen", {7'h00, seen}, {7'h00, exp_busy});
  endtask : run_cmd

  task automatic set_addr(input logic [13:0] a);
    core.wr(ADDR_ADDR_HI, {2'b00, a[13:8]});
    core.wr(ADDR_ADDR_LOW, a[7:0]);
  endtask : set_addr

  task automatic read_byte(input string name, input logic [13:0] a, input logic [7:0] exp);
    logic [7:0] d;
    set_addr(a);
    run_cmd(CMD_READ, 1'b1, 1'b1);
    core.rd(ADDR_BUFFER, d);
    check(name, d, exp);
  endtask : read_byte

  task automatic write_byte(input logic [13:0] a, input logic [7:0] d, input logic [7:0] c);
    set_addr(a);
    core.wr(ADDR_BUFFER, d);
    run_cmd(c, 1'b1, 1'b1);
  endtask : write_byte

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  initial begin
    logic [7:0] d;
    rstn = 1'b0;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    for (int i = 0; i < 10; i++) begin
      core.rd(ra[i], d);
      check("reset_value", d, rv[i]);
    end
    read_byte("erased", 14'h0123, ERASED);
    set_addr(14'h0123);
    core.wr(ADDR_BUFFER, 8'h00);
    run_cmd(CMD_WRITE, 1'b0, 1'b0);
    read_byte("no_key_write", 14'h0123, ERASED);
    write_byte(14'h0123, 8'h5a, CMD_WRITE);
    read_byte("write", 14'h0123, 8'h5a);
    core.rd(ADDR_ACC_KEY, d);
    check("key_cleared", d, 8'hff);
    run_cmd(CMD_VERIFY, 1'b1, 1'b1);
    check("verify_ok", {7'h00, verify_ok}, 8'h01);
    write_byte(14'h0123, 8'h0f, CMD_WRITE);
    read_byte("clear_only", 14'h0123, 8'h0a);
    run_cmd(CMD_VERIFY, 1'b1, 1'b1);
    check("verify_fail", {7'h00, verify_ok}, 8'h00);
    write_byte(14'h0200, 8'h11, CMD_WRITE);
    set_addr(14'h01ff);
    run_cmd(CMD_ERASE_PAGE, 1'b1, 1'b1);
    read_byte("page_erased", 14'h0123, ERASED);
    read_byte("next_page_kept", 14'h0200, 8'h11);
    write_byte(14'h0200, 8'h22, CMD_ERASE_WRITE);
    read_byte("erase_write", 14'h0200, 8'h22);
    write_byte(14'h0200, 8'h00, 8'h07);
    read_byte("unknown_cmd", 14'h0200, 8'h22);
    write_byte(14'h3ff9, 8'h33, CMD_WRITE);
    read_byte("page31_user", 14'h3ff9, 8'h33);
    run_cmd(CMD_ERASE_ALL, 1'b1, 1'b1);
    read_byte("mass_erased", 14'h0200, ERASED);
    read_byte("mass_erased31", 14'h3ff9, ERASED);
    write_byte(14'h0010, 8'h55, CMD_WRITE);
    // Page 31 locked by its own byte; pages 0 and 15 by the protect command
    write_byte(LOC_WEP3, 8'h7f, CMD_WRITE);
    core.wr(ADDR_WEP_LOW, 8'hfe);
    core.wr(ADDR_WEP_HIGH, 8'h7f);
    run_cmd(CMD_PROTECT, 1'b1, 1'b1);
    read_byte("wep_stored", LOC_WEP0, 8'hfe);
    read_byte("wep_hi_stored", 14'h3ffd, 8'h7f);
    read_byte("rd_prot_stored", LOC_RD_PROT, 8'hff);
    write_byte(14'h0010, 8'h00, CMD_WRITE);
    read_byte("protected_page", 14'h0010, 8'h55);
    write_byte(14'h3ff9, 8'h00, CMD_WRITE);
    read_byte("page31_locked", 14'h3ff9, ERASED);
    write_byte(14'h0210, 8'h44, CMD_WRITE);
    read_byte("open_page", 14'h0210, 8'h44);
    set_addr(14'h0010);
    run_cmd(CMD_ERASE_PAGE, 1'b1, 1'b1);
    read_byte("protected_erase", 14'h0010, 8'h55);
    read_byte("other_page_kept", 14'h0210, 8'h44);
    core.wr(ADDR_PROT_KEY, 8'h5c);
    core.wr(ADDR_RD_PROT, 8'hfe);
    run_cmd(CMD_PROTECT, 1'b1, 1'b1);
    read_byte("read_locked", 14'h0010, ERASED);
    read_byte("read_open", LOC_WEP0, 8'hfe);
    core.wr(ADDR_PROT_KEY, 8'h00);
    core.wr(ADDR_RD_PROT, 8'h00);
    run_cmd(CMD_PROTECT, 1'b1, 1'b1);
    read_byte("prot_key_refused", LOC_RD_PROT, 8'hfe);
    end_sim();
  end

  initial begin
    num_errors = 0;
    num_checks = 0;
    cycles     = 0;
  end
endmodule : tb_paged_flash_controller
